/* hw/starter_command_input_router.sv */
// command input router of a motor soft starter: input functions, command
// source, reversing relay, jog, analog output scaling and node address
// assumes field inputs are asynchronous; the firing core gives its quantities
// Behaviour
// - second input takes function code off or 1 to 4
// - input with error reset function clears error when driven active
// - input with external fault function raises fault when open
// - general enable input must be held active; opening means emergency stop
// - three-wire mode: first input starts, second input stops
// - third input code 4 drives first relay while active, relay code 3
// - fourth input code 4 applies jog voltage while held active
// - 8-bit analog output source: off, current, voltage, power factor, thermal
// - gain 1.00 full scale: 500% current, 100% voltage, pf 1.00, 250% thermal
// - analog quantity is multiplied by programmable gain before conversion
// - source off: start/stop from inputs; on: panel and serial only
// - source change only with motor off; to inputs needs open start, else error
// - jog and reversal from inputs when source off, serial when on
// - first general enable to open stops; serial enable needs all closed
// - external fault only from inputs two to four, any one open raises it
// - error reset from panel, serial or any assigned input pulse
// - hold node address, respond only to messages for that address
`timescale 1ns/1ps
`include "starter_params.svh"
module starter_command_input_router #(
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_start_input,
    input wire logic i_second_input,
    input wire logic i_third_input,
    input wire logic i_fourth_input,
    input wire logic [2:0] i_input_two_function_select,
    input wire logic [2:0] i_input_three_function_select,
    input wire logic [2:0] i_input_four_function_select,
    input wire logic [1:0] i_relay_one_function_select,
    input wire logic [7:0] i_jog_voltage_level,
    input wire logic [2:0] i_analog_out_source_select,
    input wire logic [7:0] i_analog_out_gain,
    input wire logic [9:0] i_current_pct,
    input wire logic [9:0] i_voltage_pct,
    input wire logic [9:0] i_power_factor,
    input wire logic [9:0] i_thermal_pct,
    input wire logic i_command_source_wr,
    input wire logic i_command_source_select,
    input wire logic i_motor_running,
    input wire logic i_panel_start,
    input wire logic i_panel_stop,
    input wire logic i_panel_error_reset,
    input wire logic i_serial_start,
    input wire logic i_serial_stop,
    input wire logic i_serial_error_reset,
    input wire logic i_serial_jog,
    input wire logic i_serial_reverse,
    input wire logic i_serial_enable,
    input wire logic i_node_address_wr,
    input wire logic [7:0] i_network_node_address,
    input wire logic i_msg_valid,
    input wire logic [7:0] i_msg_address,
    output logic o_run_request,
    output logic o_error_reset,
    output logic o_external_fault,
    output logic o_emergency_stop,
    output logic o_first_output_relay,
    output logic o_jog_active,
    output logic [7:0] o_jog_voltage,
    output logic [7:0] o_analog_out,
    output logic o_command_source,
    output logic o_programming_error,
    output logic [7:0] o_network_node_address,
    output logic o_msg_accept
);
    // =======================================================
    // input filtering
    logic [3:0] pin_vec;
    logic [3:0] lvl;
    assign pin_vec = {i_fourth_input, i_third_input, i_second_input, i_start_input};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_filt
            input_filter #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_filt (
                .i_clk_sys(i_clk_sys),
                .i_rst_n(i_rst_n),
                .i_pin(pin_vec[gi]),
                .o_level(lvl[gi])
            );
        end
    endgenerate

    // =======================================================
    // analog scaling
    // full scale at gain 100 (1.00); divide by constants so no divider is built
    function automatic starter_pkg::ao_code_t ao_scale(input logic [2:0] src,
                                                      input logic [9:0] q,
                                                      input logic [7:0] gain);
        logic [31:0] prod;
        logic [31:0] code;
        prod = 32'(q) * 32'(gain) * `AO_CODE_MAX;
        case (src)
            `AO_SRC_CURRENT: code = prod / `AO_FS_CURRENT;
            `AO_SRC_VOLTAGE: code = prod / `AO_FS_VOLTAGE;
            `AO_SRC_PFACTOR: code = prod / `AO_FS_PFACTOR;
            `AO_SRC_THERMAL: code = prod / `AO_FS_THERMAL;
            default: code = 32'h0;
        endcase
        if (code > `AO_CODE_MAX)
            code = `AO_CODE_MAX;
        return code[7:0];
    endfunction : ao_scale

    // =======================================================
    // state
    starter_pkg::run_state_e run_r, run_nxt;
    logic [3:0] lvl_d_r, lvl_d_nxt;
    logic err_rst_r, err_rst_nxt;
    logic ext_r, ext_nxt;
    logic emg_r, emg_nxt;
    logic relay_r, relay_nxt;
    logic jog_r, jog_nxt;
    logic [7:0] jogv_r, jogv_nxt;
    logic [7:0] ao_r, ao_nxt;
    logic src_r, src_nxt;
    logic perr_r, perr_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic acc_r, acc_nxt;

    starter_pkg::func_code_t fn [1:3];
    assign fn[1] = i_input_two_function_select;
    assign fn[2] = i_input_three_function_select;
    assign fn[3] = i_input_four_function_select;

    // next values of every control output
    always_comb
    begin
        logic any_rst;
        logic ext;
        logic ge_open;
        logic three_wire;
        logic start_cmd;
        logic stop_cmd;
        any_rst = i_panel_error_reset | i_serial_error_reset;
        ext = 1'b0;
        ge_open = 1'b0;
        three_wire = 1'b0;
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        for (int k = 1; k < 4; k++)
        begin
            // only a fresh rising edge resets, holding does not repeat
            if (fn[k] == `FN_ERR_RESET && lvl[k] && !lvl_d_r[k])
                any_rst = 1'b1;
            if (fn[k] == `FN_EXT_FAULT && !lvl[k])
                ext = 1'b1;
            if (fn[k] == `FN_GEN_ENABLE && !lvl[k])
                ge_open = 1'b1;
        end
        three_wire = (fn[1] == `FN_SPECIAL);
        lvl_d_nxt = lvl;
        err_rst_nxt = any_rst;
        ext_nxt = ext;
        emg_nxt = ge_open;
        // serial control also needs the serial enable alongside closed inputs
        if (src_r == `CMD_SRC_PANEL)
        begin
            start_cmd = i_panel_start | i_serial_start;
            stop_cmd = i_panel_stop | i_serial_stop | !i_serial_enable;
        end
        else if (three_wire)
        begin
            start_cmd = lvl[0] && !lvl_d_r[0];
            stop_cmd = !lvl[1];
        end
        else
        begin
            start_cmd = lvl[0];
            stop_cmd = !lvl[0];
        end
        stop_cmd = stop_cmd | ge_open | ext;
        run_nxt = run_r;
        case (run_r)
            starter_pkg::ST_STOPPED:
                if (start_cmd && !stop_cmd)
                    run_nxt = starter_pkg::ST_RUNNING;
            starter_pkg::ST_RUNNING:
                if (stop_cmd)
                    run_nxt = starter_pkg::ST_STOPPED;
            default: run_nxt = starter_pkg::ST_STOPPED;
        endcase
        // reversal and jog follow inputs or serial by command source
        if (src_r == `CMD_SRC_PANEL)
        begin
            relay_nxt = i_serial_reverse;
            jog_nxt = i_serial_jog;
        end
        else
        begin
            relay_nxt = (fn[2] == `FN_SPECIAL) && lvl[2];
            jog_nxt = (fn[3] == `FN_SPECIAL) && lvl[3];
        end
        relay_nxt = relay_nxt && (i_relay_one_function_select == `RELAY_FN_REVERSE);
        jogv_nxt = jog_nxt ? i_jog_voltage_level : 8'h00;
        case (i_analog_out_source_select)
            `AO_SRC_CURRENT: ao_nxt = ao_scale(i_analog_out_source_select, i_current_pct,
                                               i_analog_out_gain);
            `AO_SRC_VOLTAGE: ao_nxt = ao_scale(i_analog_out_source_select, i_voltage_pct,
                                               i_analog_out_gain);
            `AO_SRC_PFACTOR: ao_nxt = ao_scale(i_analog_out_source_select, i_power_factor,
                                               i_analog_out_gain);
            `AO_SRC_THERMAL: ao_nxt = ao_scale(i_analog_out_source_select, i_thermal_pct,
                                               i_analog_out_gain);
            default: ao_nxt = 8'h00;
        endcase
        // source change is refused with the motor on; to inputs needs open start
        src_nxt = src_r;
        perr_nxt = perr_r && !any_rst;
        if (i_command_source_wr && !i_motor_running)
        begin
            if (i_command_source_select == `CMD_SRC_INPUTS && lvl[0])
                perr_nxt = 1'b1;
            else
                src_nxt = i_command_source_select;
        end
        addr_nxt = i_node_address_wr ? i_network_node_address : addr_r;
        acc_nxt = i_msg_valid && (i_msg_address == addr_r);
    end

    // registers
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            run_r <= starter_pkg::ST_STOPPED;
            lvl_d_r <= 4'h0;
            err_rst_r <= 1'b0;
            ext_r <= 1'b0;
            emg_r <= 1'b0;
            relay_r <= 1'b0;
            jog_r <= 1'b0;
            jogv_r <= 8'h00;
            ao_r <= 8'h00;
            src_r <= `CMD_SRC_INPUTS;
            perr_r <= 1'b0;
            addr_r <= `NODE_ADDR_RESET;
            acc_r <= 1'b0;
        end
        else
        begin
            run_r <= run_nxt;
            lvl_d_r <= lvl_d_nxt;
            err_rst_r <= err_rst_nxt;
            ext_r <= ext_nxt;
            emg_r <= emg_nxt;
            relay_r <= relay_nxt;
            jog_r <= jog_nxt;
            jogv_r <= jogv_nxt;
            ao_r <= ao_nxt;
            src_r <= src_nxt;
            perr_r <= perr_nxt;
            addr_r <= addr_nxt;
            acc_r <= acc_nxt;
        end
    end

    assign o_run_request = (run_r == starter_pkg::ST_RUNNING);
    assign o_error_reset = err_rst_r;
    assign o_external_fault = ext_r;
    assign o_emergency_stop = emg_r;
    assign o_first_output_relay = relay_r;
    assign o_jog_active = jog_r;
    assign o_jog_voltage = jogv_r;
    assign o_analog_out = ao_r;
    assign o_command_source = src_r;
    assign o_programming_error = perr_r;
    assign o_network_node_address = addr_r;
    assign o_msg_accept = acc_r;

    // =======================================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    AST_EXT_FAULT: assert property ((fn[2] == `FN_EXT_FAULT && !lvl[2]) |=> o_external_fault)
        else $error("external fault missed on open input");
    AST_EMG: assert property ((fn[3] == `FN_GEN_ENABLE && !lvl[3]) |=> o_emergency_stop)
        else $error("general enable open without emergency stop");
    AST_EMG_STOP: assert property (o_emergency_stop |-> !o_run_request)
        else $error("running during emergency stop");
    AST_RST_ONCE: assert property (o_error_reset && !$past(i_panel_error_reset)
        && !$past(i_serial_error_reset) |=> !o_error_reset)
        else $error("input error reset longer than one cycle");
    AST_SRC_LOCK: assert property (i_motor_running |=> $stable(o_command_source))
        else $error("command source changed with motor on");
    AST_E24: assert property ((i_command_source_wr && !i_motor_running && lvl[0]
        && i_command_source_select == `CMD_SRC_INPUTS) |=> o_programming_error)
        else $error("programming error not raised");
    AST_RELAY: assert property ((o_command_source == `CMD_SRC_INPUTS && fn[2] == `FN_SPECIAL
        && lvl[2] && i_relay_one_function_select == `RELAY_FN_REVERSE)
        |=> o_first_output_relay)
        else $error("reversing relay not energised");
    AST_JOG: assert property (o_jog_active |-> o_jog_voltage == $past(i_jog_voltage_level))
        else $error("jog voltage not applied");
    AST_ADDR: assert property (o_msg_accept |-> $past(i_msg_address) == $past(addr_r))
        else $error("message accepted for another address");
    AST_AO_OFF: assert property (i_analog_out_source_select == `FN_OFF |=> o_analog_out == 8'h00)
        else $error("analog output active with source off");
    AST_PANEL_START: assert property ((o_command_source == `CMD_SRC_INPUTS && !o_run_request
        && !lvl[0] && fn[1] != `FN_SPECIAL) |=> !o_run_request)
        else $error("start without input in input mode");

    COV_RUN: cover property (!o_run_request ##1 o_run_request);
    COV_E24: cover property (!o_programming_error ##1 o_programming_error);
    COV_RELAY: cover property (o_first_output_relay);
    COV_JOG: cover property (o_jog_active && o_command_source == `CMD_SRC_PANEL);
endmodule : starter_command_input_router

/* hw/starter_params.svh */
// constants of the soft starter command input router
// assumes a 250 MHz system clock and active-high field inputs after isolation
`ifndef STARTER_PARAMS_SVH
`define STARTER_PARAMS_SVH

// =======================================================
// clock and filter timing
`define CLK_MHZ 250
`define DEBOUNCE_US 1000
`define DEBOUNCE_CYCLES (`DEBOUNCE_US * `CLK_MHZ)

// =======================================================
// digital input function codes
`define FN_OFF 3'h0
`define FN_ERR_RESET 3'h1
`define FN_EXT_FAULT 3'h2
`define FN_GEN_ENABLE 3'h3
`define FN_SPECIAL 3'h4

// =======================================================
// relay, analog and command source codes
`define RELAY_FN_REVERSE 2'h3
`define AO_SRC_CURRENT 3'h1
`define AO_SRC_VOLTAGE 3'h2
`define AO_SRC_PFACTOR 3'h3
`define AO_SRC_THERMAL 3'h4
`define AO_FS_CURRENT 32'h0000_c350
`define AO_FS_VOLTAGE 32'h0000_2710
`define AO_FS_PFACTOR 32'h0000_2710
`define AO_FS_THERMAL 32'h0000_61a8
`define AO_CODE_MAX 32'h0000_00ff
`define CMD_SRC_INPUTS 1'b0
`define CMD_SRC_PANEL 1'b1
`define NODE_ADDR_RESET 8'h01

`endif

/* hw/starter_pkg.sv */
// shared types of the soft starter command input router
// assumes starter_params.svh gives the code values
package starter_pkg;
    typedef logic [2:0] func_code_t;
    typedef logic [7:0] ao_code_t;
    typedef enum logic {ST_STOPPED, ST_RUNNING} run_state_e;
endpackage : starter_pkg

/* hw/input_filter.sv */
// two-flop synchroniser followed by a stability counter for one contact
// assumes the raw pin is asynchronous to i_clk_sys
`timescale 1ns/1ps
`include "starter_params.svh"
module input_filter #(
    parameter int unsigned STABLE_CYCLES = `DEBOUNCE_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_level
);
    logic meta_r;
    logic sync_r;
    logic level_r;
    logic level_nxt;
    logic [31:0] count_r;
    logic [31:0] count_nxt;

    // =======================================================
    // filter
    // count while the synced level differs; a bounce restarts the wait
    always_comb
    begin
        level_nxt = level_r;
        count_nxt = 32'h0;
        if (sync_r != level_r)
        begin
            count_nxt = count_r + 32'h1;
            if (count_r >= STABLE_CYCLES - 1)
            begin
                level_nxt = sync_r;
                count_nxt = 32'h0;
            end
        end
    end

    // registers; meta_r is read by sync_r only
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            level_r <= 1'b0;
            count_r <= 32'h0;
        end
        else
        begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            level_r <= level_nxt;
            count_r <= count_nxt;
        end
    end

    assign o_level = level_r;
endmodule : input_filter

/* bench/field_contact_model.sv */
// field contact model: four dry contacts wired to the router's inputs
// assumes the bench sets the wanted level and a chatter request per contact
`timescale 1ns/1ps
module field_contact_model (
    input wire logic i_clk_sys,
    input wire logic [3:0] i_level,
    input wire logic [3:0] i_chatter,
    output logic [3:0] o_pin
);
    // =====================================================
    // contact bounce source
    logic [3:0] toggle_r = 4'h0;

    // flips every cycle, so a chattering contact is never stable long
    always_ff @(posedge i_clk_sys)
    begin
        toggle_r <= ~toggle_r;
    end

    // a contact holds its set level steady unless chatter is requested, then it follows toggle_r
    assign o_pin = (i_level & ~i_chatter) | (toggle_r & i_chatter);
endmodule : field_contact_model

/* bench/starter_command_input_router_tb.sv */
// self-checking bench of the soft starter command input router
// assumes field_contact_model and a 250 MHz clock; debounce shortened to 4
`timescale 1ns/1ps
module starter_command_input_router_tb;
    // =====================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] lvl, chat;
    wire [3:0] pin;
    logic [2:0] fn2, fn3, fn4, ao_src;
    logic [1:0] rl_sel;
    logic [7:0] jog_lvl, gain, addr, msg_addr, a;
    logic [9:0] cur, volt, pf, therm;
    logic cs_wr, cs_sel, running, p_start, p_stop, p_rst, s_start, s_stop, s_rst;
    logic s_jog, s_rev, s_en, addr_wr, msg_v;
    wire run_req, err_rst, ext_flt, estop, relay, jog_act, cmd_src, prog_err, msg_acc;
    wire [7:0] jog_v, ao, node;
    int miscompares = 0;
    int checked = 0;
    int pulses = 0;
    int seed;
    int fsv[5] = '{0, 500, 100, 100, 250};

    // 4 ns period
    always #2 clk = ~clk;

    field_contact_model contacts (.i_clk_sys(clk), .i_level(lvl), .i_chatter(chat), .o_pin(pin));

    starter_command_input_router #(.DEBOUNCE_CYCLES(4)) dut (
        .i_clk_sys(clk), .i_rst_n(rst_n),
        .i_start_input(pin[0]), .i_second_input(pin[1]),
        .i_third_input(pin[2]), .i_fourth_input(pin[3]),
        .i_input_two_function_select(fn2), .i_input_three_function_select(fn3),
        .i_input_four_function_select(fn4), .i_relay_one_function_select(rl_sel),
        .i_jog_voltage_level(jog_lvl), .i_analog_out_source_select(ao_src),
        .i_analog_out_gain(gain), .i_current_pct(cur), .i_voltage_pct(volt),
        .i_power_factor(pf), .i_thermal_pct(therm),
        .i_command_source_wr(cs_wr), .i_command_source_select(cs_sel),
        .i_motor_running(running), .i_panel_start(p_start), .i_panel_stop(p_stop),
        .i_panel_error_reset(p_rst), .i_serial_start(s_start), .i_serial_stop(s_stop),
        .i_serial_error_reset(s_rst), .i_serial_jog(s_jog), .i_serial_reverse(s_rev),
        .i_serial_enable(s_en), .i_node_address_wr(addr_wr),
        .i_network_node_address(addr), .i_msg_valid(msg_v), .i_msg_address(msg_addr),
        .o_run_request(run_req), .o_error_reset(err_rst), .o_external_fault(ext_flt),
        .o_emergency_stop(estop), .o_first_output_relay(relay), .o_jog_active(jog_act),
        .o_jog_voltage(jog_v), .o_analog_out(ao), .o_command_source(cmd_src),
        .o_programming_error(prog_err), .o_network_node_address(node),
        .o_msg_accept(msg_acc)
    );

    // =====================================================
    // reference model and comparisons
    function automatic int ao_model(input int src, input int g);
        int q;
        int v;
        if (src == 0) return 0;
        q = (src == 1) ? cur : (src == 2) ? volt : (src == 3) ? pf : therm;
        v = q * g * 255 / (fsv[src] * 100);
        return (v > 255) ? 255 : v;
    endfunction : ao_model

    task chk(input logic act, input logic exp, input string what);
        checked++;
        if (act !== exp)
        begin
            miscompares++;
            $display("Error at %0t: %s got %b expected %b", $time, what, act, exp);
        end
    endtask : chk

    task chk8(input logic [7:0] act, input logic [7:0] exp, input string what);
        checked++;
        if (act !== exp)
        begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, act, exp);
        end
    endtask : chk8

    // waits past sync and debounce, counting reset pulses meanwhile
    task settle(input int n);
        repeat (n)
        begin
            @(negedge clk);
            if (err_rst === 1'b1) pulses++;
        end
    endtask : settle

    // one-cycle request launched and dropped on falling edges
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask : pulse

    task tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    // =====================================================
    // hang guard, well beyond the few hundred cycles needed
    initial
    begin
        #200000;
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // =====================================================
    // test sequence
    initial
    begin
        {lvl, chat, fn2, fn3, fn4, ao_src, rl_sel, jog_lvl, gain, addr, msg_addr} = '0;
        {cur, volt, pf, therm, cs_wr, cs_sel, running, p_start, p_stop, p_rst} = '0;
        {s_start, s_stop, s_rst, s_jog, s_rev, s_en, addr_wr, msg_v} = '0;
        seed = $urandom(96120);
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk(run_req | ext_flt | estop | relay | jog_act | cmd_src | prog_err, 1'b0, "reset");
        chk8(node, 8'h01, "reset node");
        $display("test reset done");
        // every source code, full scale first, then random quantities
        for (int s = 0; s < 5; s++)
            for (int k = 0; k < 6; k++)
            begin
                ao_src = 3'(s);
                {cur, volt, pf, therm} = {10'h1f4, 10'h064, 10'h064, 10'h0fa};
                gain = 8'h64;
                if (k > 0) {cur, volt, pf, therm, gain} = 48'($urandom) ^ {16'($urandom), 32'h0};
                @(negedge clk);
                chk8(ao, 8'(ao_model(s, gain)), "analog");
            end
        $display("test analog done");
        chat[0] = 1'b1;
        settle(3);
        chat[0] = 1'b0;
        settle(12);
        chk(run_req, 1'b0, "bounce");
        lvl[0] = 1'b1;
        settle(12);
        chk(run_req, 1'b1, "two wire run");
        {fn2, fn3} = {3'h2, 3'h2};
        lvl[2:1] = 2'b10;
        settle(12);
        chk(ext_flt, 1'b1, "fault any open");
        chk(run_req, 1'b0, "fault stops");
        lvl[1] = 1'b1;
        settle(12);
        chk(ext_flt, 1'b0, "fault clear");
        {fn2, fn3, fn4} = {3'h0, 3'h3, 3'h3};
        lvl[3:1] = 3'b011;
        settle(12);
        chk(estop, 1'b1, "enable open");
        chk(run_req, 1'b0, "enable stops");
        {fn2, fn3, fn4, lvl} = {3'h1, 3'h0, 3'h1, 4'h0};
        settle(12);
        chk(estop | ext_flt, 1'b0, "unassigned quiet");
        $display("test fault done");
        pulses = 0;
        lvl[1] = 1'b1;
        settle(16);
        chk(pulses == 1, 1'b1, "held reset once");
        pulses = 0;
        lvl[3:1] = 3'b100;
        settle(16);
        chk(pulses == 1, 1'b1, "fourth input reset");
        pulse(p_rst);
        chk(err_rst, 1'b1, "panel reset");
        pulse(s_rst);
        chk(err_rst, 1'b1, "serial reset");
        $display("test error reset done");
        {fn2, fn3, fn4, rl_sel, jog_lvl} = {3'h0, 3'h4, 3'h4, 2'h3, 8'($urandom)};
        lvl = 4'hc;
        settle(12);
        chk(relay, 1'b1, "reverse relay");
        chk(jog_act, 1'b1, "jog");
        chk8(jog_v, jog_lvl, "jog level");
        rl_sel = 2'h2;
        repeat (2) @(negedge clk);
        chk(relay, 1'b0, "relay selector");
        {lvl, rl_sel} = {4'h0, 2'h3};
        settle(12);
        chk8(jog_v, 8'h00, "jog released");
        $display("test relay jog done");
        {fn2, fn3, fn4, lvl} = {3'h4, 3'h0, 3'h0, 4'h2};
        settle(12);
        lvl[0] = 1'b1;
        settle(12);
        lvl[0] = 1'b0;
        settle(12);
        chk(run_req, 1'b1, "three wire hold");
        lvl[1] = 1'b0;
        settle(12);
        chk(run_req, 1'b0, "three wire stop");
        fn2 = 3'h0;
        $display("test three wire done");
        {cs_sel, s_en, lvl[0]} = 3'b111;
        pulse(cs_wr);
        chk(cmd_src, 1'b1, "source panel");
        settle(12);
        chk(run_req, 1'b0, "start input ignored");
        pulse(p_start);
        chk(run_req, 1'b1, "panel start");
        pulse(p_stop);
        chk(run_req, 1'b0, "panel stop");
        pulse(s_start);
        chk(run_req, 1'b1, "serial start");
        @(negedge clk) s_en = 1'b0;
        @(negedge clk) s_en = 1'b1;
        chk(run_req, 1'b0, "serial enable");
        {fn3, fn4, s_jog, s_rev} = {3'h4, 3'h4, 2'b11};
        repeat (2) @(negedge clk);
        chk(jog_act & relay, 1'b1, "serial jog reverse");
        {fn3, fn4, s_jog, s_rev, cs_sel} = '0;
        running = 1'b1;
        pulse(cs_wr);
        chk(cmd_src, 1'b1, "write while running");
        running = 1'b0;
        pulse(cs_wr);
        chk(prog_err, 1'b1, "closed start refused");
        chk(cmd_src, 1'b1, "source kept");
        pulse(p_rst);
        @(negedge clk);
        chk(prog_err, 1'b0, "error cleared");
        lvl[0] = 1'b0;
        settle(12);
        pulse(cs_wr);
        chk(cmd_src, 1'b0, "source inputs");
        $display("test command source done");
        for (int i = 0; i < 4; i++)
        begin
            a = 8'($urandom);
            addr = a;
            pulse(addr_wr);
            chk8(node, a, "node address");
            msg_addr = i[0] ? a : a ^ 8'h5a;
            pulse(msg_v);
            chk(msg_acc, i[0], "message filter");
        end
        $display("test address done");
        tally_and_finish();
    end
endmodule : starter_command_input_router_tb
